// ### verilog/adc_seq_pkg.sv
// Purpose: Shared constants for the converter sequencer control block
// Assumes: 16-bit registers, one per aligned APB word at byte address 4*index
// Notes: Indices are kept as printed; the byte address is four times the index
package adc_seq_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   localparam int RES_W = 10;
   localparam int CHAN_W = 3;
   localparam int DIV_W = 4;
   localparam int SMP_W = 3;
   localparam int PRE_W = 15;

   // Register indices
   localparam logic [ADDR_W-3:0] IDX_RESULT = 18'h05380;
   localparam logic [ADDR_W-3:0] IDX_TRIGGER = 18'h05382;
   localparam logic [ADDR_W-3:0] IDX_CONTROL = 18'h05384;
   localparam logic [ADDR_W-3:0] IDX_CLKDIV = 18'h05386;

   // trigger_channel_select fields
   localparam int LAST_CHAN_LSB = 11;
   localparam int FIRST_CHAN_LSB = 8;
   localparam int ALIGN_BIT = 7;
   localparam int MODE_BIT = 6;
   localparam int TRIG_LSB = 4;
   localparam int SMP_LSB = 0;

   // control_status fields
   localparam int CUR_CHAN_LSB = 12;
   localparam int BUSY_BIT = 10;
   localparam int OVW_BIT = 9;
   localparam int DONE_BIT = 8;
   localparam int OVW_IE_BIT = 5;
   localparam int DONE_IE_BIT = 4;
   localparam int RUN_BIT = 1;
   localparam int EN_BIT = 0;

   // Left-aligned result position
   localparam int LEFT_SHIFT = 6;

   // Reset values
   localparam logic [SMP_W-1:0] SMP_RESET = 3'h7;
   localparam logic [DIV_W-1:0] DIV_RESET = 4'h0;
   localparam logic [1:0] TRIG_RESET = 2'h0;

   // Trigger source codes
   localparam logic [1:0] TRIG_SOFTWARE = 2'h0;
   localparam logic [1:0] TRIG_TIMER = 2'h1;
   localparam logic [1:0] TRIG_EXT_PIN = 2'h3;

   // Sampling lasts code plus this many conversion-clock cycles
   localparam logic [SMP_W:0] SMP_EXTRA = 4'h2;
   // Highest usable divider code, the next one is reserved
   localparam logic [DIV_W-1:0] DIV_MAX_CODE = 4'hE;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT_TRIG,
      ST_SAMPLE,
      ST_CONVERT
   } seq_state_t;
endpackage : adc_seq_pkg

// ### verilog/conv_clk_divider.sv
// Purpose: Conversion clock enable, divided from the peripheral clock
// Assumes: One clock; the output is a one-cycle enable pulse
// Notes: Ratio is 2^(code+1); the reserved top code gives no pulse
`timescale 1ns/10ps
module conv_clk_divider
   import adc_seq_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic run,
   input wire logic [adc_seq_pkg::DIV_W-1:0] div_code,
   output logic conv_clk_en
);
   logic [PRE_W-1:0] count;
   logic [PRE_W-1:0] count_inc;
   logic [PRE_W-1:0] mask;

   // Look one count ahead so the registered pulse lands in the last cycle of the first period after entry
   assign count_inc = count + 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // Low code+1 bits all ones marks the end of one conversion clock
   always_comb begin
      mask = '0;
      for (int i = 0; i < PRE_W; i++) begin
         mask[i] = (i <= int'(div_code));
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         count <= '0;
         conv_clk_en <= 1'b0;
      end else if (!run) begin
         // Restart the phase so each sweep sees a full first period
         count <= '0;
         conv_clk_en <= 1'b0;
      end else begin
         count <= count_inc;
         conv_clk_en <= (div_code <= DIV_MAX_CODE) && ((count_inc & mask) == mask);
      end
   end
endmodule : conv_clk_divider

// ### verilog/adc_seq_ctrl.sv
// Purpose: Trigger, channel sweep, result and status logic of the ten-bit converter
// Assumes: APB slave with zero wait states; converter core on core_clk
// Notes: Trigger pin is asynchronous and synchronised before use
//
// Functional notes
// - With alignment select 0 the result sits in bits 9..0 and bits 15..10 read zero.
// - With alignment select 1 the result sits in bits 15..6 and bits 5..0 read zero.
// - Alignment select is read/write bit 7 of trigger_channel_select, reset 0.
// - First channel is bits 10..8 and last channel bits 13..11, each 0..7, reset 0.
// - Bit 6 of trigger_channel_select picks continuous (1) or single (0), reset 0.
// - Trigger select 0 is software, 1 timer channel 1, 2 reserved, 3 external pin; reset 0.
// - Sampling lasts code plus two conversion-clock cycles, code resets to 7.
// - Conversion clock is the core clock divided by 2 at code 0, doubling per code to 1/32768 at 0xE; 0xF reserved.
// - Bits 14..12 of control_status read the channel now being converted, reset 0.
// - Bit 10 of control_status reads 1 while a conversion is in progress.
// - Overwrite flag bit 9 is set on an overwrite and cleared by writing 1.
// - Completion flag bit 8 is set at each completed conversion and cleared by reading the result.
// - Bit 4 enables the completion interrupt and bit 5 the overwrite interrupt, both reset 0.
// - Writing 1 to control bit 1 starts conversion and 0 stops it, reset 0.
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
module adc_seq_ctrl
   import adc_seq_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [adc_seq_pkg::ADDR_W-1:0] paddr,
   input wire logic [adc_seq_pkg::DATA_W-1:0] pwdata,
   output logic [adc_seq_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Trigger sources
   input wire logic timer_trig,
   input wire logic ext_trigger_pin_n,
   // Converter core
   output logic converter_enable,
   output logic [adc_seq_pkg::CHAN_W-1:0] core_chan,
   output logic core_sample,
   output logic core_start,
   input wire logic core_done,
   input wire logic [adc_seq_pkg::RES_W-1:0] core_data,
   // Interrupt request
   output logic irq
);
   import adc_seq_pkg::*;

   typedef struct packed {
      logic [CHAN_W-1:0] last_chan_sel;
      logic [CHAN_W-1:0] first_chan_sel;
      logic result_align_sel;
      logic conv_mode_sel;
      logic [1:0] trigger_src_sel;
      logic [SMP_W-1:0] sample_time_sel;
      logic overwrite_err_flag;
      logic conv_done_flag;
      logic overwrite_irq_en;
      logic done_irq_en;
      logic conv_run_ctrl;
      logic converter_enable;
      logic [DIV_W-1:0] conv_clk_div_sel;
      logic [REG_W-1:0] result;
      seq_state_t state;
      logic [CHAN_W-1:0] chan;
      logic [SMP_W:0] smp_cnt;
      logic start_pulse;
      logic pin_meta;
      logic pin_sync;
      logic pin_prev;
      logic [DATA_W-1:0] rdata;
   } state_t;

   state_t cur;
   state_t next;
   logic conv_clk_en;
   logic wr_access;
   logic rd_access;
   logic setup_rd;
   logic trig_seen;
   logic result_read;
   logic sweep_start;
   logic [REG_W-1:0] rd_word;

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-3:0] idx);
      reg_hit = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'h0);
   endfunction : reg_hit

   function automatic logic mapped(input logic [ADDR_W-1:0] addr);
      mapped = reg_hit(addr, IDX_RESULT) || reg_hit(addr, IDX_TRIGGER) ||
               reg_hit(addr, IDX_CONTROL) || reg_hit(addr, IDX_CLKDIV);
   endfunction : mapped

   function automatic logic [REG_W-1:0] align_result(input logic [RES_W-1:0] data, input logic left);
      align_result = '0;
      if (left) begin
         align_result[REG_W-1:LEFT_SHIFT] = data;
      end else begin
         align_result[RES_W-1:0] = data;
      end
   endfunction : align_result

   ////////////////////////////////////////////////////////////////////////
   // Conversion clock enable
   conv_clk_divider u_div (
      .core_clk(core_clk),
      .rstn(rstn),
      .run(cur.state == ST_SAMPLE),
      .div_code(cur.conv_clk_div_sel),
      .conv_clk_en(conv_clk_en)
   );

   ////////////////////////////////////////////////////////////////////////
   // Bus and port wiring
   // Zero wait states: read data is captured in the setup cycle
   assign pready = psel && penable;
   assign pslverr = psel && penable && !mapped(paddr);
   assign wr_access = psel && penable && pwrite && mapped(paddr);
   assign rd_access = psel && penable && !pwrite;
   assign setup_rd = psel && !penable && !pwrite;
   assign result_read = rd_access && reg_hit(paddr, IDX_RESULT);
   assign prdata = cur.rdata;
   assign converter_enable = cur.converter_enable;
   assign core_chan = cur.chan;
   assign core_sample = (cur.state == ST_SAMPLE);
   assign core_start = cur.start_pulse;
   assign irq = (cur.conv_done_flag && cur.done_irq_en) || (cur.overwrite_err_flag && cur.overwrite_irq_en);

   ////////////////////////////////////////////////////////////////////////
   // Read mux
   always_comb begin
      rd_word = '0;
      if (reg_hit(paddr, IDX_RESULT)) begin
         rd_word = cur.result;
      end else if (reg_hit(paddr, IDX_TRIGGER)) begin
         rd_word[LAST_CHAN_LSB +: CHAN_W] = cur.last_chan_sel;
         rd_word[FIRST_CHAN_LSB +: CHAN_W] = cur.first_chan_sel;
         rd_word[ALIGN_BIT] = cur.result_align_sel;
         rd_word[MODE_BIT] = cur.conv_mode_sel;
         rd_word[TRIG_LSB +: 2] = cur.trigger_src_sel;
         rd_word[SMP_LSB +: SMP_W] = cur.sample_time_sel;
      end else if (reg_hit(paddr, IDX_CONTROL)) begin
         rd_word[CUR_CHAN_LSB +: CHAN_W] = cur.chan;
         rd_word[BUSY_BIT] = (cur.state == ST_SAMPLE) || (cur.state == ST_CONVERT);
         rd_word[OVW_BIT] = cur.overwrite_err_flag;
         rd_word[DONE_BIT] = cur.conv_done_flag;
         rd_word[OVW_IE_BIT] = cur.overwrite_irq_en;
         rd_word[DONE_IE_BIT] = cur.done_irq_en;
         rd_word[RUN_BIT] = cur.conv_run_ctrl;
         rd_word[EN_BIT] = cur.converter_enable;
      end else if (reg_hit(paddr, IDX_CLKDIV)) begin
         rd_word[DIV_W-1:0] = cur.conv_clk_div_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Trigger decode; reserved code never fires
   always_comb begin
      unique case (cur.trigger_src_sel)
         TRIG_SOFTWARE: trig_seen = 1'b1;
         TRIG_TIMER: trig_seen = timer_trig;
         TRIG_EXT_PIN: trig_seen = cur.pin_prev && !cur.pin_sync;
         default: trig_seen = 1'b0;
      endcase
   end

   assign sweep_start = cur.converter_enable && cur.conv_run_ctrl && trig_seen;

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next = cur;
      next.start_pulse = 1'b0;
      next.pin_meta = ext_trigger_pin_n;
      next.pin_sync = cur.pin_meta;
      next.pin_prev = cur.pin_sync;
      if (setup_rd) begin
         next.rdata = {{(DATA_W-REG_W){1'b0}}, rd_word};
      end

      // Register writes
      if (wr_access && reg_hit(paddr, IDX_TRIGGER)) begin
         next.last_chan_sel = pwdata[LAST_CHAN_LSB +: CHAN_W];
         next.first_chan_sel = pwdata[FIRST_CHAN_LSB +: CHAN_W];
         next.result_align_sel = pwdata[ALIGN_BIT];
         next.conv_mode_sel = pwdata[MODE_BIT];
         next.trigger_src_sel = pwdata[TRIG_LSB +: 2];
         next.sample_time_sel = pwdata[SMP_LSB +: SMP_W];
      end
      if (wr_access && reg_hit(paddr, IDX_CONTROL)) begin
         if (pwdata[OVW_BIT]) begin
            next.overwrite_err_flag = 1'b0;
         end
         next.overwrite_irq_en = pwdata[OVW_IE_BIT];
         next.done_irq_en = pwdata[DONE_IE_BIT];
         next.conv_run_ctrl = pwdata[RUN_BIT];
         next.converter_enable = pwdata[EN_BIT];
      end
      if (wr_access && reg_hit(paddr, IDX_CLKDIV)) begin
         next.conv_clk_div_sel = pwdata[DIV_W-1:0];
      end
      if (result_read) begin
         next.conv_done_flag = 1'b0;
      end

      // Sequencer
      // Written values, so sampling never outlives a cleared enable
      if (!next.converter_enable || !next.conv_run_ctrl) begin
         // Stop aborts at once; a conversion in the core is discarded
         next.state = ST_IDLE;
         next.smp_cnt = '0;
      end else begin
         unique case (cur.state)
            ST_IDLE, ST_WAIT_TRIG: begin
               if (sweep_start) begin
                  next.state = ST_SAMPLE;
                  next.chan = cur.first_chan_sel;
                  next.smp_cnt = '0;
               end else begin
                  next.state = ST_WAIT_TRIG;
               end
            end
            ST_SAMPLE: begin
               if (conv_clk_en) begin
                  if (cur.smp_cnt == {1'b0, cur.sample_time_sel} + SMP_EXTRA - 1'b1) begin
                     next.state = ST_CONVERT;
                     next.start_pulse = 1'b1;
                     next.smp_cnt = '0;
                  end else begin
                     next.smp_cnt = cur.smp_cnt + 1'b1;
                  end
               end
            end
            ST_CONVERT: begin
               if (core_done) begin
                  next.result = align_result(core_data, cur.result_align_sel);
                  // Set wins over a same-cycle read clear
                  next.conv_done_flag = 1'b1;
                  if (cur.conv_done_flag && !result_read) begin
                     next.overwrite_err_flag = 1'b1;
                  end
                  if (cur.chan != cur.last_chan_sel) begin
                     next.chan = cur.chan + 1'b1;
                     next.state = ST_SAMPLE;
                  end else if (cur.conv_mode_sel) begin
                     next.chan = cur.first_chan_sel;
                     next.state = (cur.trigger_src_sel == TRIG_SOFTWARE) ? ST_SAMPLE : ST_WAIT_TRIG;
                  end else begin
                     next.state = ST_IDLE;
                     next.conv_run_ctrl = 1'b0;
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cur <= '0;
         cur.sample_time_sel <= SMP_RESET;
         cur.trigger_src_sel <= TRIG_RESET;
         cur.conv_clk_div_sel <= DIV_RESET;
         cur.state <= ST_IDLE;
         cur.pin_meta <= 1'b1;
         cur.pin_sync <= 1'b1;
         cur.pin_prev <= 1'b1;
      end else begin
         cur <= next;
      end
   end
endmodule : adc_seq_ctrl

// ### bench/adc_seq_ctrl_sva.sv
// Purpose: Port assertions for adc_seq_ctrl
// Assumes: Zero-wait APB, byte address four times index
// Notes: Sampling length is judged by the bench
`timescale 1ns/10ps
module adc_seq_ctrl_sva
   import adc_seq_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [adc_seq_pkg::ADDR_W-1:0] paddr,
   input wire logic [adc_seq_pkg::DATA_W-1:0] pwdata,
   input wire logic [adc_seq_pkg::DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic timer_trig,
   input wire logic ext_trigger_pin_n,
   input wire logic converter_enable,
   input wire logic [adc_seq_pkg::CHAN_W-1:0] core_chan,
   input wire logic core_sample,
   input wire logic core_start,
   input wire logic core_done,
   input wire logic [adc_seq_pkg::RES_W-1:0] core_data,
   input wire logic irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   logic mapped;
   assign mapped = paddr inside {20'h14E00, 20'h14E08, 20'h14E10, 20'h14E18};
   ////////////////////////////////////////////////////////////////
   chk_ready_access: assert property (pready == (psel && penable))
      else $error("pready not tied to access phase");
   chk_slverr_map: assert property (psel && penable |-> pslverr == !mapped)
      else $error("pslverr disagrees with address map");
   chk_unmapped_zero: assert property (pslverr && !pwrite |-> prdata == 32'h00000000)
      else $error("unmapped read returned data");
   chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   chk_start_pulse: assert property (core_start |=> !core_start && !core_sample)
      else $error("start pulse too long");
   chk_start_after: assert property (core_start |-> $past(core_sample) && !core_sample)
      else $error("start without preceding sampling");
   chk_chan_steady: assert property (core_sample && $past(core_sample) |-> $stable(core_chan))
      else $error("channel moved during sampling");
   chk_disable_idle: assert property (!converter_enable |-> !core_sample && !core_start)
      else $error("converter active while disabled");
endmodule : adc_seq_ctrl_sva

bind adc_seq_ctrl adc_seq_ctrl_sva u_sva (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .timer_trig(timer_trig), .ext_trigger_pin_n(ext_trigger_pin_n), .converter_enable(converter_enable),
   .core_chan(core_chan), .core_sample(core_sample), .core_start(core_start), .core_done(core_done),
   .core_data(core_data), .irq(irq));

// ### bench/conv_core_model.sv
// Purpose: Behavioural analogue core answering core_start
// Assumes: Latency set by the bench, at least one cycle
// Notes: Result is the channel number over a fixed pattern
`timescale 1ns/10ps
module conv_core_model (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic core_start,
   input wire logic [2:0] core_chan,
   input wire logic [7:0] lat,
   output logic core_done,
   output logic [9:0] core_data
);
   logic [7:0] cnt;
   logic [2:0] ch;
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= 8'h00;
         ch <= 3'h0;
         core_done <= 1'b0;
         core_data <= 10'h2AA;
      end else begin
         core_done <= 1'b0;
         // Data toggles outside done so a stale value never matches
         core_data <= ~core_data;
         if (core_start) begin
            cnt <= lat;
            ch <= core_chan;
         end else if (cnt == 8'h01) begin
            cnt <= 8'h00;
            core_done <= 1'b1;
            core_data <= {ch, 7'h5A};
         end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule : conv_core_model

// ### bench/adc_seq_ctrl_bench.sv
// Purpose: Self-checking bench for adc_seq_ctrl
// Assumes: Zero-wait APB slave, core model latency 20
// Notes: Start records hold channel and sampling length
`timescale 1ns/10ps
module adc_seq_ctrl_bench;
   import adc_seq_pkg::*;
   logic core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [19:0] paddr = 20'h00000;
   logic [31:0] pwdata = 32'h00000000, prdata;
   logic pready, pslverr, timer_trig = 1'b0, ext_trigger_pin_n = 1'b1;
   logic converter_enable, core_sample, core_start, core_done, irq;
   logic [2:0] core_chan;
   logic [9:0] core_data;
   logic [7:0] lat = 8'h14, scnt = 8'h00;
   logic [10:0] starts[$];
   int failures = 0, check_count = 0;
   always #2.5 core_clk = ~core_clk;
   adc_seq_ctrl u_adc_seq_ctrl (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_trig(timer_trig), .ext_trigger_pin_n(ext_trigger_pin_n), .converter_enable(converter_enable),
      .core_chan(core_chan), .core_sample(core_sample), .core_start(core_start), .core_done(core_done),
      .core_data(core_data), .irq(irq));
   conv_core_model u_conv_core_model (.core_clk(core_clk), .rstn(rstn), .core_start(core_start),
      .core_chan(core_chan), .lat(lat), .core_done(core_done), .core_data(core_data));
   always @(posedge core_clk) begin
      if (core_sample === 1'b1) scnt <= scnt + 8'h01;
      if (core_start === 1'b1) begin
         starts.push_back({core_chan, scnt});
         scnt <= 8'h00;
      end
   end
   ////////////////////////////////////////////////////////////////
   task automatic results();
      if (failures == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : cmp
   task automatic apb(input logic w, input logic [17:0] idx, input logic [15:0] wd,
                      output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {16'h0000, wd};
      @(posedge core_clk);
      penable <= 1'b1;
      // Wait states come from the slave; only the watchdog ends a hang
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge keeps a following request from reassigning psel now
      @(posedge core_clk);
   endtask : apb
   task automatic wr(input logic [17:0] idx, input logic [15:0] v);
      logic [31:0] d;
      logic e;
      apb(1'b1, idx, v, d, e);
   endtask : wr
   task automatic chk(input logic [17:0] idx, input logic [15:0] mask, input logic [15:0] exp, input string m);
      logic [31:0] d;
      logic e;
      apb(1'b0, idx, 16'h0000, d, e);
      cmp(d & {16'h0000, mask}, {16'h0000, exp}, m);
   endtask : chk
   task automatic wait_starts(input int n);
      int k;
      k = 0;
      while (starts.size() < n && k < 5000) begin
         @(posedge core_clk);
         k++;
      end
      cmp(32'(starts.size()), 32'(n), "start count");
   endtask : wait_starts
   task automatic cmp_irq(input logic exp);
      @(negedge core_clk);
      cmp(32'(irq), 32'(exp), "irq level");
      // Back on a rising edge before the next bus request
      @(posedge core_clk);
   endtask : cmp_irq
   ////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [31:0] d;
      logic e;
      chk(IDX_TRIGGER, 16'hFFFF, 16'h0007, "trigger reset");
      chk(IDX_CONTROL, 16'hFFFF, 16'h0000, "control reset");
      chk(IDX_CLKDIV, 16'hFFFF, 16'h0000, "divider reset");
      wr(IDX_RESULT, 16'hFFFF);
      chk(IDX_RESULT, 16'hFFFF, 16'h0000, "result read only");
      apb(1'b0, 18'h05381, 16'h0000, d, e);
      cmp(32'(e) | d, 32'h00000001, "unmapped access");
   endtask : t_reset
   task automatic t_single();
      starts.delete();
      wr(IDX_TRIGGER, 16'h1A00);
      wr(IDX_CONTROL, 16'h0013);
      chk(IDX_CONTROL, 16'hFFFF, 16'h2413, "busy on channel two");
      @(negedge core_clk);
      cmp(32'(converter_enable), 32'h1, "converter enable pin");
      @(posedge core_clk);
      wait_starts(2);
      cmp(32'(starts[0]), {21'h0, 3'd2, 8'd4}, "first sweep step");
      cmp(32'(starts[1]), {21'h0, 3'd3, 8'd4}, "second sweep step");
      repeat (25) @(posedge core_clk);
      chk(IDX_CONTROL, 16'h0FFF, 16'h0311, "single sweep end");
      cmp_irq(1'b1);
      chk(IDX_RESULT, 16'hFFFF, {6'h00, 3'd3, 7'h5A}, "right aligned");
      chk(IDX_CONTROL, 16'h0FFF, 16'h0211, "done cleared by read");
      cmp_irq(1'b0);
      wr(IDX_CONTROL, 16'h0031);
      chk(IDX_CONTROL, 16'h0FFF, 16'h0231, "write zero keeps overwrite");
      cmp_irq(1'b1);
      wr(IDX_CONTROL, 16'h0201);
      chk(IDX_CONTROL, 16'h0FFF, 16'h0001, "overwrite cleared");
   endtask : t_single
   task automatic trig_case(input logic [1:0] m, input int on_timer, input int on_pin);
      starts.delete();
      wr(IDX_TRIGGER, {10'h000, m, 4'h0});
      wr(IDX_CONTROL, 16'h0003);
      repeat (20) @(posedge core_clk);
      cmp(32'(starts.size()), 32'h0, "start without trigger");
      timer_trig <= 1'b1;
      @(posedge core_clk);
      timer_trig <= 1'b0;
      repeat (10) @(posedge core_clk);
      cmp(32'(starts.size()), 32'(on_timer), "timer trigger");
      ext_trigger_pin_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      ext_trigger_pin_n <= 1'b1;
      repeat (10) @(posedge core_clk);
      cmp(32'(starts.size()), 32'(on_timer | on_pin), "pin trigger");
      wr(IDX_CONTROL, 16'h0001);
      repeat (25) @(posedge core_clk);
   endtask : trig_case
   task automatic t_cont();
      logic [31:0] d;
      logic e;
      // Flags left by the trigger cases would turn the first result into an overwrite
      apb(1'b0, IDX_RESULT, 16'h0000, d, e);
      wr(IDX_CONTROL, 16'h0201);
      starts.delete();
      wr(IDX_CLKDIV, 16'h0001);
      wr(IDX_TRIGGER, 16'h2DC1);
      wr(IDX_CONTROL, 16'h0003);
      wait_starts(2);
      cmp(32'(starts[0]), {21'h0, 3'd5, 8'd12}, "slow sampling");
      cmp(32'(starts[1]), {21'h0, 3'd5, 8'd12}, "sweep repeated");
      wr(IDX_CONTROL, 16'h0001);
      repeat (30) @(posedge core_clk);
      cmp(32'(starts.size()), 32'h2, "stopped sweep");
      chk(IDX_CONTROL, 16'h0FFF, 16'h0101, "idle after stop");
      chk(IDX_RESULT, 16'hFFFF, {3'd5, 7'h5A, 6'h00}, "left aligned");
   endtask : t_cont
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      results();
   end
   initial begin
      repeat (12) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      t_reset();
      t_single();
      trig_case(TRIG_TIMER, 1, 0);
      trig_case(TRIG_EXT_PIN, 0, 1);
      trig_case(2'h2, 0, 0);
      t_cont();
      results();
   end
endmodule : adc_seq_ctrl_bench
